// ==== logic/coproc_transfer_primitive_exec.sv ====
`timescale 1ns/10ps
module coproc_transfer_primitive_exec (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             cir_req,
	output logic             cir_wr,
	output logic      [1:0]  cir_sel,
	output logic      [31:0] cir_wdata,
	input  wire logic [31:0] cir_rdata,
	input  wire logic        cir_ack,
	output logic             mem_req,
	output logic             mem_wr,
	output logic      [31:0] mem_addr,
	output logic      [2:0]  mem_len,
	output logic      [31:0] mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             proto_viol
);
	typedef struct packed {
		cp_pkg::state_t   state;
		logic [15:0]      prim;
		logic             cond;
		logic [15:0]      mask;
		logic [4:0]       step;
		logic [3:0]       rsel;
		logic [2:0]       cidx;
		logic [31:0]      op;
		logic [31:0]      sp;
		logic             wait_rf;
		logic [7:0][31:0] creg;
		logic             done;
		logic             viol;
		logic             viol_pulse;
		logic             cir_req;
		logic             cir_wr;
		logic [1:0]       cir_sel;
		logic [31:0]      cir_wdata;
		logic             mem_req;
		logic             mem_wr;
		logic [31:0]      mem_addr;
		logic [2:0]       mem_len;
		logic [31:0]      mem_wdata;
		logic             pready;
		logic             pslverr;
		logic             apb_wait;
		logic [31:0]      prdata;
		logic [4:0]       ridx;
	} core_t;

	core_t st;
	core_t next_st;

	rf_if rf ();

	logic        dec_valid;
	logic [2:0]  dec_idx;
	logic [4:0]  ptype;
	logic        ca;
	logic        dir;
	logic [7:0]  len;
	logic        len_ok;
	logic [31:0] sp_step;
	logic [3:0]  step_reg;
	logic        viol_set;
	logic        done_set;
	logic        clr_done;
	logic        clr_viol;
	logic        apb_err;

	reg_store u_store (
		.pclk    (pclk),
		.presetn (presetn),
		.rf      (rf)
	);

	ctrl_decode u_decode (
		.code  (cir_rdata[15:0]),
		.valid (dec_valid),
		.idx   (dec_idx)
	);

	// ****************************************
	// Primitive field decode
	// ****************************************
	assign ptype   = st.prim[12:8];
	assign ca      = st.prim[cp_pkg::CA_BIT];
	assign dir     = st.prim[cp_pkg::DIR_BIT];
	assign len     = st.prim[7:0];
	assign len_ok  = (len == cp_pkg::LEN_BYTE) || (len == cp_pkg::LEN_WORD) || (len == cp_pkg::LEN_LONG);
	// Byte operands move the stack by two to keep it word aligned
	assign sp_step = (len == cp_pkg::LEN_BYTE) ? cp_pkg::SP_BYTE_STEP : {24'h00_0000, len};
	// Step 0..7 gives data 7..0, step 8..15 gives address 7..0
	assign step_reg = {st.step[3], ~st.step[2:0]};

	// ****************************************
	// Engine and bus slave
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.viol_pulse = 1'h0;
		viol_set = 1'h0;
		done_set = 1'h0;
		clr_done = 1'h0;
		clr_viol = 1'h0;
		apb_err  = 1'h0;
		rf.we    = 1'h0;
		rf.waddr = st.rsel;
		rf.wdata = st.op;
		rf.raddr = (st.state == cp_pkg::S_IDLE) ? st.ridx[3:0] : st.rsel;

		case (st.state)
			cp_pkg::S_IDLE: begin
			end
			cp_pkg::S_DECODE: begin
				next_st.wait_rf = 1'h0;
				// No category gate beyond the come-again check
				if (st.cond && !ca) begin
					viol_set = 1'h1;
				end else if (ptype == cp_pkg::TYPE_TOS) begin
					if (!len_ok) begin
						viol_set = 1'h1;
					end else begin
						next_st.rsel  = cp_pkg::SP_INDEX;
						next_st.state = cp_pkg::S_RF_RD;
					end
				end else if (ptype == cp_pkg::TYPE_SINGLE) begin
					next_st.rsel  = st.prim[3:0];
					next_st.state = dir ? cp_pkg::S_OPIN : cp_pkg::S_RF_RD;
				end else if (ptype == cp_pkg::TYPE_CTRL || ptype == cp_pkg::TYPE_MULTI) begin
					next_st.state = cp_pkg::S_SEL;
				end else begin
					viol_set = 1'h1;
				end
			end
			cp_pkg::S_RF_RD: begin
				// Register store answers one cycle after the address
				if (!st.wait_rf) begin
					next_st.wait_rf = 1'h1;
				end else begin
					next_st.wait_rf = 1'h0;
					if (ptype == cp_pkg::TYPE_TOS && dir) begin
						next_st.sp    = rf.rdata - sp_step;
						rf.we         = 1'h1;
						rf.waddr      = cp_pkg::SP_INDEX;
						rf.wdata      = rf.rdata - sp_step;
						next_st.state = cp_pkg::S_OPIN;
					end else if (ptype == cp_pkg::TYPE_TOS) begin
						next_st.sp    = rf.rdata;
						next_st.state = cp_pkg::S_MEM;
					end else begin
						next_st.op    = rf.rdata;
						next_st.state = cp_pkg::S_OPOUT;
					end
				end
			end
			cp_pkg::S_MEM: begin
				if (mem_ack) begin
					if (dir) begin
						next_st.state = cp_pkg::S_FINISH;
					end else begin
						next_st.op    = mem_rdata;
						rf.we         = 1'h1;
						rf.waddr      = cp_pkg::SP_INDEX;
						rf.wdata      = st.sp + sp_step;
						next_st.state = cp_pkg::S_OPOUT;
					end
				end
			end
			cp_pkg::S_SEL: begin
				if (cir_ack) begin
					if (ptype == cp_pkg::TYPE_CTRL) begin
						if (!dec_valid) begin
							viol_set = 1'h1;
						end else begin
							next_st.cidx = dec_idx;
							if (dir) begin
								next_st.state = cp_pkg::S_OPIN;
							end else begin
								next_st.op    = st.creg[dec_idx];
								next_st.state = cp_pkg::S_OPOUT;
							end
						end
					end else begin
						next_st.mask  = cir_rdata[15:0];
						next_st.step  = 5'h00;
						next_st.state = cp_pkg::S_SCAN;
					end
				end
			end
			cp_pkg::S_SCAN: begin
				// One walk serves both directions
				if (st.step[4]) begin
					next_st.state = cp_pkg::S_FINISH;
				end else if (st.mask[step_reg]) begin
					next_st.rsel  = step_reg;
					next_st.state = dir ? cp_pkg::S_OPIN : cp_pkg::S_RF_RD;
				end else begin
					next_st.step = st.step + 5'h01;
				end
			end
			cp_pkg::S_OPOUT: begin
				if (cir_ack) begin
					if (ptype == cp_pkg::TYPE_MULTI) begin
						next_st.step  = st.step + 5'h01;
						next_st.state = cp_pkg::S_SCAN;
					end else begin
						next_st.state = cp_pkg::S_FINISH;
					end
				end
			end
			cp_pkg::S_OPIN: begin
				if (cir_ack) begin
					next_st.op = cir_rdata;
					if (ptype == cp_pkg::TYPE_TOS) begin
						next_st.state = cp_pkg::S_MEM;
					end else if (ptype == cp_pkg::TYPE_CTRL) begin
						next_st.creg[st.cidx] = cir_rdata;
						next_st.state = cp_pkg::S_FINISH;
					end else begin
						rf.we    = 1'h1;
						rf.wdata = cir_rdata;
						if (ptype == cp_pkg::TYPE_MULTI) begin
							next_st.step  = st.step + 5'h01;
							next_st.state = cp_pkg::S_SCAN;
						end else begin
							next_st.state = cp_pkg::S_FINISH;
						end
					end
				end
			end
			cp_pkg::S_FINISH: begin
				if (ca) begin
					next_st.state = cp_pkg::S_RESP;
				end else begin
					done_set      = 1'h1;
					next_st.state = cp_pkg::S_IDLE;
				end
			end
			cp_pkg::S_RESP: begin
				if (cir_ack) begin
					next_st.prim  = cir_rdata[15:0];
					next_st.state = cp_pkg::S_DECODE;
				end
			end
			default: begin
				next_st.state = cp_pkg::S_IDLE;
			end
		endcase

		if (viol_set) begin
			next_st.state      = cp_pkg::S_IDLE;
			next_st.viol_pulse = 1'h1;
		end

		// Access phase: two wait cycles, then pready; effects at the pready edge
		next_st.pready  = 1'h0;
		next_st.pslverr = 1'h0;
		if (psel && penable) begin
			if (st.pready) begin
				next_st.apb_wait = 1'h0;
				if (pwrite && !st.pslverr) begin
					if (paddr == cp_pkg::ADDR_PRIM) begin
						next_st.prim  = pwdata[15:0];
						next_st.cond  = pwdata[cp_pkg::COND_BIT];
						next_st.state = cp_pkg::S_DECODE;
					end else if (paddr == cp_pkg::ADDR_STAT) begin
						clr_done = pwdata[cp_pkg::STAT_DONE];
						clr_viol = pwdata[cp_pkg::STAT_VIOL];
					end else if (paddr == cp_pkg::ADDR_RIDX) begin
						next_st.ridx = pwdata[4:0];
					end else if (st.ridx[4]) begin
						next_st.creg[st.ridx[2:0]] = pwdata;
					end else begin
						rf.we    = 1'h1;
						rf.waddr = st.ridx[3:0];
						rf.wdata = pwdata;
					end
				end
			end else if (st.apb_wait) begin
				next_st.apb_wait = 1'h0;
				next_st.pready   = 1'h1;
				if (paddr == cp_pkg::ADDR_PRIM) begin
					apb_err        = pwrite && (st.state != cp_pkg::S_IDLE);
					next_st.prdata = {15'h0000, st.cond, st.prim};
				end else if (paddr == cp_pkg::ADDR_STAT) begin
					next_st.prdata = {29'h0000_0000, st.viol, st.done, st.state != cp_pkg::S_IDLE};
				end else if (paddr == cp_pkg::ADDR_RIDX) begin
					next_st.prdata = {27'h000_0000, st.ridx};
				end else if (paddr == cp_pkg::ADDR_RDATA) begin
					apb_err        = st.ridx[4] && st.ridx[3];
					next_st.prdata = st.ridx[4] ? st.creg[st.ridx[2:0]] : rf.rdata;
				end else begin
					apb_err        = 1'h1;
					next_st.prdata = cp_pkg::RESET_WORD;
				end
				next_st.pslverr = apb_err;
			end else if (!(paddr == cp_pkg::ADDR_RDATA && st.state != cp_pkg::S_IDLE)) begin
				// Register window waits while the engine owns the store
				next_st.apb_wait = 1'h1;
			end
		end

		// Hardware set wins over software clear
		next_st.done = (st.done && !clr_done) || done_set;
		next_st.viol = (st.viol && !clr_viol) || viol_set;

		// Port requests follow the next state so they come from flops
		next_st.cir_req   = (next_st.state == cp_pkg::S_SEL) || (next_st.state == cp_pkg::S_OPOUT)
			|| (next_st.state == cp_pkg::S_OPIN) || (next_st.state == cp_pkg::S_RESP);
		next_st.cir_wr    = (next_st.state == cp_pkg::S_OPOUT);
		next_st.cir_sel   = (next_st.state == cp_pkg::S_SEL) ? cp_pkg::CIR_RSEL
			: (next_st.state == cp_pkg::S_RESP) ? cp_pkg::CIR_RESP : cp_pkg::CIR_OPER;
		next_st.cir_wdata = next_st.op;
		next_st.mem_req   = (next_st.state == cp_pkg::S_MEM);
		next_st.mem_wr    = next_st.prim[cp_pkg::DIR_BIT];
		next_st.mem_addr  = next_st.sp;
		next_st.mem_len   = next_st.prim[2:0];
		next_st.mem_wdata = next_st.op;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata     = st.prdata;
	assign pready     = st.pready;
	assign pslverr    = st.pslverr;
	assign cir_req    = st.cir_req;
	assign cir_wr     = st.cir_wr;
	assign cir_sel    = st.cir_sel;
	assign cir_wdata  = st.cir_wdata;
	assign mem_req    = st.mem_req;
	assign mem_wr     = st.mem_wr;
	assign mem_addr   = st.mem_addr;
	assign mem_len    = st.mem_len;
	assign mem_wdata  = st.mem_wdata;
	assign proto_viol = st.viol_pulse;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	cond_ca_a: assert property (
		st.state == cp_pkg::S_DECODE && st.cond && !ca |=> proto_viol && st.state == cp_pkg::S_IDLE)
		else $error("conditional primitive without come-again not rejected");
	tos_len_a: assert property (
		st.state == cp_pkg::S_DECODE && !(st.cond && !ca) && ptype == cp_pkg::TYPE_TOS && !len_ok
		|=> proto_viol)
		else $error("bad stack length not rejected");
	pop_addr_a: assert property (
		st.state == cp_pkg::S_RF_RD && st.wait_rf && ptype == cp_pkg::TYPE_TOS && !dir
		|=> mem_req && !mem_wr && mem_addr == $past(rf.rdata))
		else $error("pop not from stack pointer");
	pop_inc_a: assert property (
		st.state == cp_pkg::S_MEM && mem_ack && !dir && len == cp_pkg::LEN_BYTE
		|-> rf.we && rf.waddr == cp_pkg::SP_INDEX && rf.wdata == st.sp + 32'h0000_0002)
		else $error("byte pop did not advance by two");
	push_dec_a: assert property (
		st.state == cp_pkg::S_RF_RD && st.wait_rf && ptype == cp_pkg::TYPE_TOS && dir && len == cp_pkg::LEN_BYTE
		|=> st.sp == $past(rf.rdata) - 32'h0000_0002)
		else $error("byte push did not drop by two");
	push_data_a: assert property (
		st.state == cp_pkg::S_OPIN && cir_ack && ptype == cp_pkg::TYPE_TOS
		|=> mem_req && mem_wr && mem_wdata == $past(cir_rdata) && mem_addr == st.sp)
		else $error("push data or address wrong");
	ctrl_bad_a: assert property (
		st.state == cp_pkg::S_SEL && cir_ack && ptype == cp_pkg::TYPE_CTRL && !dec_valid
		|=> proto_viol ##1 !cir_req)
		else $error("invalid select code not rejected");
	mask_skip_a: assert property (
		st.state == cp_pkg::S_SCAN && !st.step[4] && !st.mask[step_reg]
		|=> st.state == cp_pkg::S_SCAN && st.step == $past(st.step) + 5'h01)
		else $error("unselected register not skipped");
	come_again_a: assert property (
		st.state == cp_pkg::S_FINISH && ca |=> cir_req && !cir_wr && cir_sel == cp_pkg::CIR_RESP)
		else $error("come-again did not reread response");
	cir_hold_a: assert property (
		cir_req && !cir_ack |=> cir_req && $stable(cir_sel) && $stable(cir_wr))
		else $error("interface request dropped early");

	multi_done_c: cover property (st.state == cp_pkg::S_FINISH && ptype == cp_pkg::TYPE_MULTI);
	byte_push_c: cover property (st.state == cp_pkg::S_MEM && mem_ack && dir && len == cp_pkg::LEN_BYTE);
	ctrl_viol_c: cover property (st.state == cp_pkg::S_SEL && cir_ack && ptype == cp_pkg::TYPE_CTRL && !dec_valid);
	chain_c: cover property (st.state == cp_pkg::S_RESP && cir_ack);
endmodule

// ==== inc/cp_pkg.sv ====
package cp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_PRIM  = 8'h00;
	localparam logic [7:0] ADDR_STAT  = 8'h04;
	localparam logic [7:0] ADDR_RIDX  = 8'h08;
	localparam logic [7:0] ADDR_RDATA = 8'h0c;
	localparam int COND_BIT  = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_VIOL = 2;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ****************************************
	// Primitive word fields and type codes
	// ****************************************
	localparam int CA_BIT  = 15;
	localparam int DIR_BIT = 13;
	localparam logic [4:0] TYPE_TOS    = 5'h0e;
	localparam logic [4:0] TYPE_SINGLE = 5'h0c;
	localparam logic [4:0] TYPE_CTRL   = 5'h0d;
	localparam logic [4:0] TYPE_MULTI  = 5'h06;
	localparam logic [7:0] LEN_BYTE    = 8'h01;
	localparam logic [7:0] LEN_WORD    = 8'h02;
	localparam logic [7:0] LEN_LONG    = 8'h04;
	localparam logic [31:0] SP_BYTE_STEP = 32'h0000_0002;

	// ****************************************
	// Interface register selects and registers
	// ****************************************
	localparam logic [1:0] CIR_RESP = 2'h0;
	localparam logic [1:0] CIR_OPER = 2'h1;
	localparam logic [1:0] CIR_RSEL = 2'h2;
	localparam logic [3:0] SP_INDEX = 4'hf;
	localparam logic [4:0] STEP_END = 5'h10;
	localparam int NUM_CTRL = 8;
	// Order: source, dest space, cache ctrl, user sp, vbr, cache addr, master sp, int sp
	localparam logic [11:0] CR_CODE [NUM_CTRL] = '{12'h000, 12'h001, 12'h002, 12'h800,
		12'h801, 12'h802, 12'h803, 12'h804};

	typedef enum logic [3:0] {
		S_IDLE, S_DECODE, S_SEL, S_SCAN, S_RF_RD, S_OPOUT, S_OPIN, S_MEM, S_FINISH, S_RESP
	} state_t;

endpackage

// ==== inc/rf_if.sv ====
`timescale 1ns/10ps
interface rf_if;
	logic        we;
	logic [3:0]  waddr;
	logic [31:0] wdata;
	logic [3:0]  raddr;
	logic [31:0] rdata;
	modport owner (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== logic/reg_store.sv ====
`timescale 1ns/10ps
// Data registers 0..7 then address registers 0..7; read data registered
module reg_store (
	input wire logic pclk,
	input wire logic presetn,
	rf_if.store      rf
);
	typedef struct packed {
		logic [15:0][31:0] word;
		logic [31:0]       rdata;
	} store_t;

	store_t st;
	store_t next_st;

	always_comb begin
		next_st = st;
		// Read sees the old word on a same-cycle write
		next_st.rdata = st.word[rf.raddr];
		if (rf.we) begin
			next_st.word[rf.waddr] = rf.wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rf.rdata = st.rdata;
endmodule

// ==== logic/ctrl_decode.sv ====
`timescale 1ns/10ps
module ctrl_decode (
	input  wire logic [15:0] code,
	output logic             valid,
	output logic [2:0]       idx
);
	logic [cp_pkg::NUM_CTRL-1:0] hit;

	// Leading hex digit is a don't-care
	for (genvar i = 0; i < cp_pkg::NUM_CTRL; i++) begin : g_cmp
		assign hit[i] = (code[11:0] == cp_pkg::CR_CODE[i]);
	end

	always_comb begin
		idx = '0;
		for (int i = 0; i < cp_pkg::NUM_CTRL; i++) begin
			if (hit[i]) begin
				idx = 3'(i);
			end
		end
	end

	assign valid = |hit;
endmodule

// ==== tb/coproc_model.sv ====
`timescale 1ns/10ps
// Far side: coprocessor interface registers plus the active stack memory
module coproc_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        cir_req,
	input  wire logic        cir_wr,
	input  wire logic [1:0]  cir_sel,
	input  wire logic [31:0] cir_wdata,
	output logic      [31:0] cir_rdata,
	output logic             cir_ack,
	input  wire logic        mem_req,
	input  wire logic        mem_wr,
	input  wire logic [31:0] mem_addr,
	input  wire logic [2:0]  mem_len,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata,
	output logic             mem_ack
);
	logic [31:0] resp_q [$];
	logic [31:0] op_in [$];
	logic [31:0] op_out [$];
	logic [31:0] mem [logic [31:0]];
	logic [15:0] sel_word = 16'h0000;
	logic [31:0] last_addr = 32'h0000_0000;
	int          lag = 0;
	int          cwait;
	int          mwait;

	// Data lines toggle when idle so a stale value never looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cir_ack <= 1'b0;
			mem_ack <= 1'b0;
			cir_rdata <= 32'h5a5a_a5a5;
			mem_rdata <= 32'ha5a5_5a5a;
			cwait = 0;
			mwait = 0;
		end else begin
			cir_ack <= 1'b0;
			mem_ack <= 1'b0;
			cir_rdata <= ~cir_rdata;
			mem_rdata <= ~mem_rdata;
			if (cir_req && !cir_ack) begin
				if (cwait < lag) begin
					cwait++;
				end else begin
					cwait = 0;
					cir_ack <= 1'b1;
					if (cir_wr) begin
						op_out.push_back(cir_wdata);
					end else begin
						case (cir_sel)
							cp_pkg::CIR_RESP: cir_rdata <= resp_q.size() ? resp_q.pop_front() : 32'h0000_0000;
							cp_pkg::CIR_RSEL: cir_rdata <= {16'h0000, sel_word};
							default: cir_rdata <= op_in.size() ? op_in.pop_front() : 32'h0000_0000;
						endcase
					end
				end
			end
			if (mem_req && !mem_ack) begin
				if (mwait < lag) begin
					mwait++;
				end else begin
					mwait = 0;
					mem_ack <= 1'b1;
					last_addr = mem_addr;
					if (mem_wr) begin
						mem[mem_addr] = mem_wdata & (32'hffff_ffff >> (32 - 8 * mem_len));
					end else begin
						mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
					end
				end
			end
		end
	end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, cir_wdata, cir_rdata, mem_addr, mem_wdata, mem_rdata;
	logic        pready, pslverr, cir_req, cir_wr, cir_ack, mem_req, mem_wr, mem_ack, proto_viol;
	logic [1:0]  cir_sel;
	logic [2:0]  mem_len;
	logic [31:0] r, v;
	logic        e;
	int          miscompares = 0;
	int          n_compared = 0;
	int          viol_n = 0;
	logic [15:0] codes [8] = '{16'hf000, 16'h1001, 16'h2002, 16'h3800, 16'h4801, 16'h5802, 16'h6803, 16'h7804};

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) if (proto_viol === 1'b1) viol_n++;

	coproc_transfer_primitive_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cir_req(cir_req), .cir_wr(cir_wr), .cir_sel(cir_sel), .cir_wdata(cir_wdata), .cir_rdata(cir_rdata),
		.cir_ack(cir_ack), .mem_req(mem_req), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_len(mem_len),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .proto_viol(proto_viol));

	coproc_model pm (.pclk(pclk), .presetn(presetn), .cir_req(cir_req), .cir_wr(cir_wr), .cir_sel(cir_sel),
		.cir_wdata(cir_wdata), .cir_rdata(cir_rdata), .cir_ack(cir_ack), .mem_req(mem_req), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_len(mem_len), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		if (pready !== 1'b1) begin
			miscompares++;
			conclude();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_reg(input logic [4:0] idx);
		apb(1'b1, cp_pkg::ADDR_RIDX, {27'h000_0000, idx});
		apb(1'b0, cp_pkg::ADDR_RDATA, 32'h0000_0000);
	endtask

	// Start a primitive and poll until the engine is idle
	task automatic run(input logic [31:0] prim);
		int n;
		apb(1'b1, cp_pkg::ADDR_PRIM, prim);
		for (n = 0; n < 100; n++) begin
			apb(1'b0, cp_pkg::ADDR_STAT, 32'h0000_0000);
			if (r[cp_pkg::STAT_BUSY] === 1'b0) break;
		end
		if (n == 100) begin
			miscompares++;
			conclude();
		end
	endtask

	// Returns done/viol bits then clears them
	task automatic stat();
		apb(1'b0, cp_pkg::ADDR_STAT, 32'h0000_0000);
		v = {29'h0000_0000, r[2:0]};
		apb(1'b1, cp_pkg::ADDR_STAT, 32'h0000_0006);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h10, 32'h0000_0000);
		`CHK(e, 1'b1)
		rd_reg(5'h0f);
		`CHK(r, 32'h0000_0000)
		pm.op_in.push_back(32'h0000_1000);
		run(32'h0000_2c0f);
		stat();
		`CHK(v, 32'h0000_0002)
		rd_reg(5'h0f);
		`CHK(r, 32'h0000_1000)
		pm.op_in.push_back(32'hcafe_0003);
		run(32'h0000_2c03);
		run(32'h0000_0c03);
		`CHK(pm.op_out.pop_front(), 32'hcafe_0003)
		rd_reg(5'h0b);
		`CHK(r, 32'h0000_0000)
		// Push then pop each legal size; byte keeps the stack word aligned
		for (int i = 0; i < 3; i++) begin
			pm.lag = i;
			pm.op_in.push_back(32'h1234_5678 + i);
			run(32'h0000_2e00 | (1 << i));
			rd_reg(5'h0f);
			`CHK(r, 32'h0000_1000 - ((i == 0) ? 2 : (1 << i)))
			`CHK(pm.last_addr, 32'h0000_1000 - ((i == 0) ? 2 : (1 << i)))
			run(32'h0000_0e00 | (1 << i));
			rd_reg(5'h0f);
			`CHK(r, 32'h0000_1000)
			`CHK(pm.op_out.pop_front(), (32'h1234_5678 + i) & (32'hffff_ffff >> (32 - 8 * (1 << i))))
		end
		// Done is sticky: clear it so only the violation bit remains
		stat();
		run(32'h0000_0e03);
		stat();
		`CHK(v, 32'h0000_0004)
		for (int i = 0; i < 8; i++) begin
			pm.sel_word = codes[i];
			pm.op_in.push_back(32'hc0de_0000 + i);
			run(32'h0000_2d00);
			rd_reg(5'h10 + i);
			`CHK(r, 32'hc0de_0000 + i)
			run(32'h0000_0d00);
			`CHK(pm.op_out.pop_front(), 32'hc0de_0000 + i)
		end
		stat();
		pm.lag = 1;
		pm.sel_word = 16'h0805;
		run(32'h0000_2d00);
		stat();
		`CHK(v, 32'h0000_0004)
		pm.sel_word = 16'h8181;
		for (int i = 0; i < 4; i++) pm.op_in.push_back(32'h0a00_0000 + i);
		run(32'h0000_2600);
		for (int i = 0; i < 4; i++) begin
			rd_reg((i[0] ? 5'h00 : 5'h07) + (i[1] ? 5'h08 : 5'h00));
			`CHK(r, 32'h0a00_0000 + i)
		end
		rd_reg(5'h03);
		`CHK(r, 32'hcafe_0003)
		run(32'h0000_0600);
		for (int i = 0; i < 4; i++) `CHK(pm.op_out.pop_front(), 32'h0a00_0000 + i)
		`CHK(pm.op_out.size(), 0)
		pm.resp_q.push_back(32'h0000_0c03);
		run(32'h0000_8c0b);
		`CHK(pm.op_out.pop_front(), 32'h0000_0000)
		`CHK(pm.op_out.pop_front(), 32'hcafe_0003)
		stat();
		`CHK(v, 32'h0000_0002)
		run(32'h0001_0c03);
		stat();
		`CHK(v, 32'h0000_0004)
		`CHK(pm.op_out.size(), 0)
		run(32'h0001_8c03);
		`CHK(pm.op_out.pop_front(), 32'hcafe_0003)
		stat();
		`CHK(v, 32'h0000_0004)
		`CHK(viol_n, 4)
		conclude();
	end
endmodule
